// *** pkg/asbl_pkg.sv ***
// Shared constants for the static RAM host controller
package asbl_pkg;
    localparam int ADDR_W = 17;
    localparam int DATA_W = 16;
    localparam int CLK_PERIOD_NS = 40;
    // Pin timing figures in ns
    localparam int T_RC_NS   = 70;
    localparam int T_AA_NS   = 70;
    localparam int T_WC_NS   = 70;
    localparam int T_AW_NS   = 60;
    localparam int T_BW_NS   = 60;
    localparam int T_SD_NS   = 30;
    localparam int T_HZWE_NS = 25;
    localparam int T_HZOE_NS = 25;
    // Least times round up to whole cycles
    localparam int RD_CYC  = (T_AA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WR_CYC0 = (T_AW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WR_CYC1 = (T_HZWE_NS + T_SD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WR_CYC  = (WR_CYC0 > WR_CYC1) ? WR_CYC0 : WR_CYC1;
    localparam int TURN_CYC = (T_HZOE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 4;
    localparam logic [CNT_W-1:0] CNT_RST = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_RST = 17'h00000;
    localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
endpackage

// *** pkg/asbl_cnt_if.sv ***
// Wait-state counter handshake between controller and timer
`timescale 1ns/100ps
interface asbl_cnt_if;
    logic                           load;
    logic [asbl_pkg::CNT_W-1:0]     count;
    logic                           done;
    modport ctl (output load, output count, input done);
    modport tmr (input load, input count, output done);
endinterface

// *** hw/asbl_wait_timer.sv ***
// Down counter that times wait states
`timescale 1ns/100ps
module asbl_wait_timer (
    input  wire logic  clk,   // Core clock
    input  wire logic  rst,   // Async reset, high
    asbl_cnt_if.tmr    cnt    // Load and done
);
    typedef struct packed {
        logic [asbl_pkg::CNT_W-1:0] remain;
    } asbl_tmr_s;
    asbl_tmr_s st_ff;
    asbl_tmr_s nxt_st;

    always_comb begin
        nxt_st = st_ff;
        if (cnt.load) begin
            nxt_st.remain = cnt.count;
        end else if (st_ff.remain != asbl_pkg::CNT_RST) begin
            nxt_st.remain = st_ff.remain - 4'h1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign cnt.done = (st_ff.remain == 4'h1);
endmodule

// *** hw/asbl_sram_host.sv ***
// Host controller driving an asynchronous 128K x 16 static RAM
// Contract
// [RL1] Memory holds 131,072 words of 16 bits on a 17-bit address.
// [RL2] Device idles in standby when unselected or both lanes off.
// [RL3] Data pins float when deselected, outputs off, lanes off, or writing.
// [RL4] Write with low lane selected stores bits 7 to 0.
// [RL5] Write with high lane selected stores bits 15 to 8; others unchanged.
// [RL6] Read drives select and output enable low, write strobe high.
// [RL7] Read drives only selected byte lanes; others float.
// [RL8] Write lasts while select and write strobe are both low.
// [RL9] Write data valid 30 ns before ending edge, 0 ns hold.
// [RL10] Strobe write with outputs on lasts turn-off plus setup time.
// [RL11] Address stable 60 ns before write end; change 0 ns around it.
// [RL12] Address presented no later than write start.
// [RL13] Byte lanes held low at least 60 ns before write end.
// [RL14] Read data valid 70 ns after address; no earlier sample.
// [RL15] Read data valid 35 ns after output enable falls.
// [RL16] Select and strobe rising together keep outputs floating.
// [RL17] Host never drives the bus while the device drives it.
// [RL18] Address valid before or with select falling on reads.
// [RL19] Each access is a state machine with counted wait states.
`timescale 1ns/100ps
module asbl_sram_host #(
    parameter int RD_CYC   = asbl_pkg::RD_CYC,   // Address to data cycles
    parameter int WR_CYC   = asbl_pkg::WR_CYC,   // Write strobe low cycles
    parameter int TURN_CYC = asbl_pkg::TURN_CYC  // Bus release cycles after a read
) (
    input  wire logic                          core_clk,        // 25 MHz clock
    input  wire logic                          rst,             // Async reset, high
    input  wire logic                          req_valid,       // Access request
    input  wire logic                          req_write,       // 1 write, 0 read
    input  wire logic [asbl_pkg::ADDR_W-1:0]   req_addr,        // Word address
    input  wire logic [asbl_pkg::DATA_W-1:0]   req_wdata,       // Write data
    input  wire logic [1:0]                    req_lane_n,      // Lane selects, low on
    output logic                               req_ready,       // Idle, request taken
    output logic                               rsp_valid,       // Read data pulse
    output logic [asbl_pkg::DATA_W-1:0]        rsp_rdata,       // Read data
    output logic [asbl_pkg::ADDR_W-1:0]        mem_addr,        // Address pins
    output logic                               chip_select_n,   // Chip select, low
    output logic                               write_strobe_n,  // Write strobe, low
    output logic                               output_drive_n,  // Output enable, low
    output logic                               low_byte_select_n,  // Low lane, low
    output logic                               high_byte_select_n, // High lane, low
    output logic [asbl_pkg::DATA_W-1:0]        data_out,        // Data pins out
    output logic                               data_oe,         // Host drives data
    input  wire logic [asbl_pkg::DATA_W-1:0]   data_in          // Data pins in
);
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RD,
        ST_RD_END,
        ST_WR,
        ST_WR_END,
        ST_TURN
    } asbl_state_e;

    // Controller state apart from the wait count, registered as one word
    typedef struct packed {
        asbl_state_e                   state;
        logic                          ready;
        logic                          rvalid;
        logic [asbl_pkg::DATA_W-1:0]   rdata;
        logic [asbl_pkg::ADDR_W-1:0]   addr;
        logic                          cs_n;
        logic                          we_n;
        logic                          oe_n;
        logic                          lb_n;
        logic                          hb_n;
        logic [asbl_pkg::DATA_W-1:0]   dout;
        logic                          doe;
        logic [asbl_pkg::DATA_W-1:0]   sync1;
        logic [asbl_pkg::DATA_W-1:0]   sync2;
    } asbl_host_s;

    asbl_host_s st_ff;
    asbl_host_s nxt_st;
    asbl_cnt_if cnt ();

    // Wait states counted by a shared down counter
    asbl_wait_timer u_timer (
        .clk (core_clk),
        .rst (rst),
        .cnt (cnt)
    );

    // Timer loads; a read waits two more cycles for the input synchroniser
    localparam logic [asbl_pkg::CNT_W-1:0] RD_WAIT   = asbl_pkg::CNT_W'(RD_CYC + 2);
    localparam logic [asbl_pkg::CNT_W-1:0] WR_WAIT   = asbl_pkg::CNT_W'(WR_CYC);
    localparam logic [asbl_pkg::CNT_W-1:0] TURN_WAIT = asbl_pkg::CNT_W'(TURN_CYC);

    // Idle word: deselected, strobes high, bus released
    localparam asbl_host_s HOST_RST = '{
        state:  ST_IDLE,
        ready:  1'b1,
        rvalid: 1'b0,
        rdata:  asbl_pkg::DATA_RST,
        addr:   asbl_pkg::ADDR_RST,
        cs_n:   1'b1,
        we_n:   1'b1,
        oe_n:   1'b1,
        lb_n:   1'b1,
        hb_n:   1'b1,
        dout:   asbl_pkg::DATA_RST,
        doe:    1'b0,
        sync1:  asbl_pkg::DATA_RST,
        sync2:  asbl_pkg::DATA_RST
    };

    // Next state; the timer answers through the interface
    always_comb begin
        nxt_st = st_ff;
        cnt.load = 1'b0;
        cnt.count = asbl_pkg::CNT_RST;
        nxt_st.rvalid = 1'b0;

        // Pin inputs pass two flops before use
        nxt_st.sync1 = data_in;
        nxt_st.sync2 = st_ff.sync1;

        unique case (st_ff.state)
            ST_IDLE: begin
                if (req_valid && st_ff.ready) begin
                    // Address, lanes and select all move at the take
                    nxt_st.ready = 1'b0;
                    nxt_st.addr = req_addr;            // RL12 RL18
                    nxt_st.lb_n = req_lane_n[0];       // RL13
                    nxt_st.hb_n = req_lane_n[1];       // RL13
                    nxt_st.cs_n = 1'b0;                // RL18
                    cnt.load = 1'b1;
                    if (req_write) begin
                        // Host drives the bus only while device outputs are off
                        nxt_st.we_n = 1'b0;            // RL8
                        nxt_st.oe_n = 1'b1;            // RL17
                        nxt_st.dout = req_wdata;       // RL4 RL5 RL9
                        nxt_st.doe = 1'b1;             // RL17
                        cnt.count = WR_WAIT;           // RL10 RL11 RL19
                        nxt_st.state = ST_WR;
                    end else begin
                        // Read holds the write strobe high and leaves the bus free
                        nxt_st.we_n = 1'b1;            // RL6
                        nxt_st.oe_n = 1'b0;            // RL6 RL15
                        nxt_st.doe = 1'b0;             // RL17
                        cnt.count = RD_WAIT;           // RL14 RL19
                        nxt_st.state = ST_RD;
                    end
                end
            end

            // Select and strobe rise on one edge to end the write
            ST_WR: begin
                if (cnt.done) begin
                    nxt_st.we_n = 1'b1;                // RL8 RL16
                    nxt_st.cs_n = 1'b1;                // RL8 RL16
                    nxt_st.state = ST_WR_END;
                end
            end

            // Data and lanes held one cycle past the write end
            ST_WR_END: begin
                nxt_st.doe = 1'b0;                     // RL9
                nxt_st.lb_n = 1'b1;                    // RL2
                nxt_st.hb_n = 1'b1;                    // RL2
                nxt_st.ready = 1'b1;
                nxt_st.state = ST_IDLE;
            end

            // Sample after the access time plus the two-flop synchroniser
            ST_RD: begin
                if (cnt.done) begin
                    nxt_st.rdata = st_ff.sync2;        // RL7 RL14
                    nxt_st.rvalid = 1'b1;
                    nxt_st.cs_n = 1'b1;                // RL2
                    nxt_st.oe_n = 1'b1;                // RL3
                    nxt_st.lb_n = 1'b1;
                    nxt_st.hb_n = 1'b1;
                    nxt_st.state = ST_RD_END;
                end
            end

            ST_RD_END: begin
                // Restart the timer for the bus release
                cnt.load = 1'b1;
                cnt.count = TURN_WAIT;                 // RL17
                nxt_st.state = ST_TURN;
            end

            // Device lets go of the bus before a write may drive it
            ST_TURN: begin
                if (cnt.done) begin
                    nxt_st.ready = 1'b1;
                    nxt_st.state = ST_IDLE;
                end
            end

            // Unused codes return to idle
            default: begin
                nxt_st.state = ST_IDLE;
            end
        endcase
    end

    // Asynchronous reset to the idle word
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st_ff <= HOST_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Every output is a register bit
    assign req_ready          = st_ff.ready;
    assign rsp_valid          = st_ff.rvalid;
    assign rsp_rdata          = st_ff.rdata;
    assign mem_addr           = st_ff.addr;
    assign chip_select_n      = st_ff.cs_n;
    assign write_strobe_n     = st_ff.we_n;
    assign output_drive_n     = st_ff.oe_n;
    assign low_byte_select_n  = st_ff.lb_n;
    assign high_byte_select_n = st_ff.hb_n;
    assign data_out           = st_ff.dout;
    assign data_oe            = st_ff.doe;
endmodule

// *** tb/asbl_sram_host_sva.sv ***
// Pin sequence checks for the static RAM host controller
`timescale 1ns/100ps
module asbl_sram_host_sva (
    input wire logic                        core_clk,           // Clock
    input wire logic                        rst,                // Reset
    input wire logic                        req_ready,          // Idle
    input wire logic                        rsp_valid,          // Read pulse
    input wire logic [asbl_pkg::ADDR_W-1:0] mem_addr,           // Address pins
    input wire logic                        chip_select_n,      // Select
    input wire logic                        write_strobe_n,     // Write strobe
    input wire logic                        output_drive_n,     // Output enable
    input wire logic                        low_byte_select_n,  // Low lane
    input wire logic                        high_byte_select_n, // High lane
    input wire logic [asbl_pkg::DATA_W-1:0] data_out,           // Bus out
    input wire logic                        data_oe             // Host drives bus
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    a_read_strobe: assert property (!chip_select_n && !output_drive_n |-> write_strobe_n)
        else $error("read with write strobe low");
    a_no_contend: assert property (data_oe |-> output_drive_n)
        else $error("host drives bus with outputs on");
    a_write_len: assert property ($fell(write_strobe_n) |-> !write_strobe_n
        ##1 !write_strobe_n ##1 write_strobe_n)
        else $error("write strobe length wrong");
    a_write_pair: assert property ($fell(write_strobe_n) |-> $fell(chip_select_n)
        ##1 !chip_select_n ##1 $rose(chip_select_n))
        else $error("select and strobe not paired");
    a_data_hold: assert property ($rose(write_strobe_n) |-> data_oe
        && $stable(data_out) && $past(data_oe, 2))
        else $error("write data not held");
    a_lane_hold: assert property (!write_strobe_n |=> $stable({low_byte_select_n,
        high_byte_select_n}))
        else $error("lanes moved in write");
    a_write_addr: assert property (!write_strobe_n |=> $stable(mem_addr))
        else $error("address moved in write");
    a_read_addr: assert property (!chip_select_n && write_strobe_n |=>
        $stable(mem_addr) || chip_select_n)
        else $error("address moved in read");
    a_read_wait: assert property ($fell(output_drive_n) |-> !output_drive_n [*4]
        ##1 (rsp_valid && output_drive_n))
        else $error("read wait wrong");
    a_bus_turn: assert property (rsp_valid |-> !req_ready ##1 !req_ready ##1 req_ready)
        else $error("turnaround wrong");
    c_write: cover property ($rose(write_strobe_n));
    c_read: cover property (rsp_valid);
    c_standby: cover property (!chip_select_n && low_byte_select_n && high_byte_select_n);
endmodule
bind asbl_sram_host asbl_sram_host_sva asbl_sram_host_sva_i (.core_clk(core_clk), .rst(rst),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .mem_addr(mem_addr), .data_out(data_out),
    .chip_select_n(chip_select_n), .write_strobe_n(write_strobe_n), .data_oe(data_oe),
    .output_drive_n(output_drive_n), .low_byte_select_n(low_byte_select_n),
    .high_byte_select_n(high_byte_select_n));

// *** tb/asbl_sram_model.sv ***
// Behavioural model of the asynchronous 128K x 16 static RAM
`timescale 1ns/100ps
module asbl_sram_model #(
    parameter int ACC_NS = 70    // Access delay
) (
    input  wire logic [16:0] mem_addr,  // Address
    input  wire logic        cs_n,      // Select
    input  wire logic        we_n,      // Write strobe
    input  wire logic        oe_n,      // Output enable
    input  wire logic        lb_n,      // Low lane
    input  wire logic        hb_n,      // High lane
    input  wire logic [15:0] data_out,  // Host bus out
    input  wire logic        data_oe,   // Host drives
    output logic      [15:0] data_in    // Bus seen by host
);
    logic [15:0] mem [0:131071];
    logic        wr;
    logic        rd;
    logic [15:0] bus;
    logic [15:0] word;
    logic [15:0] q;
    assign wr = !cs_n && !we_n;
    assign rd = !cs_n && we_n && !oe_n;
    assign bus = data_oe ? data_out : ~data_out;
    assign word = mem[mem_addr];
    // Store on the edge that ends the overlap
    always @(negedge wr) begin
        if (!lb_n) mem[mem_addr][7:0] = bus[7:0];
        if (!hb_n) mem[mem_addr][15:8] = bus[15:8];
    end
    // Unselected lanes float, shown as inverted data
    assign q = {(rd && !hb_n) ? word[15:8] : ~word[15:8], (rd && !lb_n) ? word[7:0] : ~word[7:0]};
    assign #(ACC_NS) data_in = q;
endmodule

// *** tb/asbl_sram_host_tb.sv ***
// Self-checking bench for the static RAM host controller
`timescale 1ns/100ps
module asbl_sram_host_tb;
    logic core_clk, rst, req_valid, req_write, req_ready, rsp_valid, data_oe;
    logic cs_n, we_n, oe_n, lb_n, hb_n;
    logic [16:0] req_addr, mem_addr;
    logic [15:0] req_wdata, rsp_rdata, data_out, data_in, ref_w;
    logic [1:0]  req_lane_n;
    logic [31:0] seed;
    int          err_total, samples_checked;
    asbl_sram_host asbl_sram_host_i (.core_clk(core_clk), .rst(rst), .req_valid(req_valid),
        .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
        .req_lane_n(req_lane_n), .req_ready(req_ready), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .mem_addr(mem_addr), .chip_select_n(cs_n),
        .write_strobe_n(we_n), .output_drive_n(oe_n), .low_byte_select_n(lb_n),
        .high_byte_select_n(hb_n), .data_out(data_out), .data_oe(data_oe), .data_in(data_in));
    asbl_sram_model #(.ACC_NS(70)) asbl_sram_model_i (.mem_addr(mem_addr), .cs_n(cs_n),
        .we_n(we_n), .oe_n(oe_n), .lb_n(lb_n), .hb_n(hb_n), .data_out(data_out),
        .data_oe(data_oe), .data_in(data_in));
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [15:0] lmask(input logic [1:0] ln);
        return {{8{!ln[1]}}, {8{!ln[0]}}};
    endfunction
    task automatic close_out();
        $display("checks=%0d errors=%0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One access; waits bounded, read lanes compared under mask
    task automatic acc(input logic w, input logic [16:0] a, input logic [15:0] d,
                       input logic [1:0] ln);
        int n;
        n = 0;
        @(posedge core_clk);
        req_valid <= 1'b1;
        req_write <= w;
        req_addr <= a;
        req_wdata <= d;
        req_lane_n <= ln;
        @(negedge core_clk);
        while (req_ready !== 1'b1 && n < 20) begin
            @(negedge core_clk);
            n++;
        end
        @(posedge core_clk);
        req_valid <= 1'b0;
        while (!w && rsp_valid !== 1'b1 && n < 20) begin
            @(negedge core_clk);
            n++;
        end
        if (n >= 20) begin
            err_total++;
            $display("mismatch t=%0t waited=%h limit=%h", $time, n, 20);
            close_out();
        end else if (!w) begin
            chk(rsp_rdata & lmask(ln), ref_w & lmask(ln));
        end
    endtask
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    initial begin
        logic [16:0] a;
        logic [15:0] d;
        logic [1:0]  ln;
        seed = 32'h0000003D;
        err_total = 0;
        samples_checked = 0;
        rst = 1'b1;
        req_valid = 1'b0;
        req_write = 1'b0;
        req_addr = 17'h00000;
        req_wdata = 16'h0000;
        req_lane_n = 2'h3;
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        @(negedge core_clk);
        chk({9'h000, data_oe, req_ready, cs_n, we_n, oe_n, lb_n, hb_n}, 16'h003F);
        for (int i = 0; i < 24; i++) begin
            a = (i == 0) ? 17'h00000 : (i == 1) ? 17'h1FFFF : 17'(xs());
            d = 16'(xs());
            ref_w = d;
            acc(1'b1, a, d, 2'h0);
            ln = 2'(i);
            d = 16'(xs());
            ref_w = (ref_w & ~lmask(ln)) | (d & lmask(ln));
            acc(1'b1, a, d, ln);
            acc(1'b0, a, 16'h0000, 2'(xs()));
        end
        close_out();
    end
endmodule
